// ==== src/ppm_power_regs.sv ====
// Contract
// - Wake support field bits 15:11 read zero.
// - Capabilities bit 10 reads one.
// - Capabilities bit 9 reads one.
// - Auxiliary current bits 8:6 read zero.
// - Capabilities bit 5 reads zero.
// - Capabilities bit 3 reads zero.
// - Revision field follows revision select bit.
// - D3hot to D0 causes no reset.
// - Wake event flag reads zero always.
// - Data scale and select fields read zero.
// - Bit 8 is plain read/write scratch.
// - No-soft-reset bit follows revision select bit.
// - Bits 1:0 hold and set power level.
// - Reserved bits read zero.
module ppm_power_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [1:0]  cfg_be,
    input  wire logic [15:0] cfg_wdata,
    output logic      [15:0] cfg_rdata,
    output logic             cfg_rvalid,
    input  wire logic        revision_select_bit,
    output logic      [1:0]  device_power_level
);

    // ****************************************************************
    // Address decode and the write path.
    // ****************************************************************
    ppm_csr_if csr ();

    wire hit_cap = (cfg_addr == ppm_pkg::PPM_CAP_OFS);
    wire hit_csr = (cfg_addr == ppm_pkg::PPM_CSR_OFS);

    // Writes to the capabilities word have no target at all.
    assign csr.wr_lo = cfg_wr && hit_csr && cfg_be[0];
    assign csr.wr_hi = cfg_wr && hit_csr && cfg_be[1];
    assign csr.wdata = cfg_wdata;

    ppm_csr_store u_store (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .csr     (csr)
    );

    // ****************************************************************
    // Read words.
    // ****************************************************************
    wire [2:0] power_spec_revision = revision_select_bit ?
               ppm_pkg::PPM_REV_NEW : ppm_pkg::PPM_REV_OLD;

    wire [15:0] cap_word = {
        ppm_pkg::PPM_WAKE_SUPPORT,
        1'h1,
        1'h1,
        ppm_pkg::PPM_AUX_CURRENT,
        1'h0,
        1'h0,
        1'h0,
        power_spec_revision
    };

    wire [15:0] csr_word = {
        1'h0,
        2'h0,
        4'h0,
        csr.scratch,
        4'h0,
        revision_select_bit,
        1'h0,
        2'(csr.level)
    };

    wire [15:0] rdata_nxt = hit_cap ? cap_word :
                            hit_csr ? csr_word : 16'h0000;

    logic [15:0] rdata_r;
    logic        rvalid_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'h0;
        end else begin
            rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign cfg_rdata          = rdata_r;
    assign cfg_rvalid         = rvalid_r;
    assign device_power_level = 2'(csr.level);

    // ****************************************************************
    // Checks.
    // ****************************************************************
    wire rd_cap = cfg_rd && hit_cap;
    wire rd_csr = cfg_rd && hit_csr;

    a_cap_fixed_bits: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rvalid && cfg_rdata[15:9] == 7'h03)
        else $error("Capabilities support bits read wrong.");

    a_cap_low_zeros: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[8:3] == 6'h00)
        else $error("Capabilities zero fields read nonzero.");

    a_rev_follows_sel: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[2:0] == ($past(revision_select_bit) ?
                                      3'h3 : 3'h2))
        else $error("Revision field does not follow select bit.");

    a_csr_zero_fields: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr |=> cfg_rdata[15:9] == 7'h00 && cfg_rdata[7:4] == 4'h0
                   && !cfg_rdata[2])
        else $error("Control/status fixed fields read nonzero.");

    a_nosoft_follows: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr |=> cfg_rdata[3] == $past(revision_select_bit))
        else $error("No-soft-reset bit does not follow select bit.");

    a_level_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr && !csr.wr_lo |=> cfg_rdata[1:0] == device_power_level)
        else $error("Read power level differs from held level.");

    a_wake_keeps_ctx: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n && $past(device_power_level) == 2'h3
        && device_power_level == 2'h0
        && !$past(csr.wr_hi) |-> $stable(csr.scratch))
        else $error("Context lost on return to D0.");

    a_ro_write_ignored: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !csr.wr_lo && !csr.wr_hi |=>
        $stable(device_power_level) && $stable(csr.scratch))
        else $error("State changed without a control/status write.");

    // ****************************************************************
    // Checks of single fields and of the read answer.
    // ****************************************************************
    a_wake_support_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[15:11] == 5'h00)
        else $error("Wake support field reads nonzero.");

    a_deep_doze_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[10])
        else $error("Deep doze support bit reads zero.");

    a_light_doze_bit: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[9])
        else $error("Light doze support bit reads zero.");

    a_aux_current_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> cfg_rdata[8:6] == 3'h0)
        else $error("Auxiliary current field reads nonzero.");

    a_init_bit_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> !cfg_rdata[5])
        else $error("Special initialisation bit reads one.");

    a_cap_rsvd_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> !cfg_rdata[4])
        else $error("Reserved capabilities bit reads one.");

    a_bus_clock_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_cap |=> !cfg_rdata[3])
        else $error("Wake bus clock bit reads one.");

    a_wake_flag_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr |=> !cfg_rdata[15])
        else $error("Wake event flag reads one.");

    a_data_fields_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr |=> cfg_rdata[14:9] == 6'h00)
        else $error("Data scale or select field reads nonzero.");

    a_scratch_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rd_csr && !csr.wr_hi |=> cfg_rdata[8] == csr.scratch)
        else $error("Read scratch bit differs from held bit.");

    a_level_write_only: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n && !$stable(device_power_level) |-> $past(csr.wr_lo))
        else $error("Power level moved without a low lane write.");

    a_scratch_write_only: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n && !$stable(csr.scratch) |-> $past(csr.wr_hi))
        else $error("Scratch bit moved without a high lane write.");

    a_read_answers: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_rd |=> cfg_rvalid)
        else $error("Read request got no valid answer.");

    a_rvalid_single: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !cfg_rd |=> !cfg_rvalid)
        else $error("Read valid raised without a read request.");

    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_rd && !hit_cap && !hit_csr |=> cfg_rdata == 16'h0000)
        else $error("Unmapped read returned nonzero data.");

endmodule

// ==== src/ppm_pkg.sv ====
package ppm_pkg;

    // ****************************************************************
    // Configuration offsets and reset values.
    // ****************************************************************
    localparam logic [7:0]  PPM_CAP_OFS      = 8'h52;
    localparam logic [7:0]  PPM_CSR_OFS      = 8'h54;
    localparam logic [15:0] PPM_CAP_RST      = 16'h0603;
    localparam logic [15:0] PPM_CSR_RST      = 16'h0008;

    // ****************************************************************
    // Field positions and fixed field values.
    // ****************************************************************
    localparam int          PPM_SCRATCH_BIT  = 8;
    localparam int          PPM_NOSOFT_BIT   = 3;
    localparam logic [4:0]  PPM_WAKE_SUPPORT = 5'h00;
    localparam logic [2:0]  PPM_AUX_CURRENT  = 3'h0;
    localparam logic [2:0]  PPM_REV_OLD      = 3'h2;
    localparam logic [2:0]  PPM_REV_NEW      = 3'h3;
    localparam logic        PPM_SCRATCH_RST  = 1'h0;

    typedef enum logic [1:0] {
        PPM_D0,
        PPM_D1,
        PPM_D2,
        PPM_D3HOT
    } ppm_level_e;

endpackage

// ==== src/ppm_csr_if.sv ====
interface ppm_csr_if;
    logic                wr_lo;
    logic                wr_hi;
    logic [15:0]         wdata;
    ppm_pkg::ppm_level_e level;
    logic                scratch;

    modport ctrl  (output wr_lo, output wr_hi, output wdata,
                   input level, input scratch);
    modport store (input wr_lo, input wr_hi, input wdata,
                   output level, output scratch);
endinterface

// ==== src/ppm_csr_store.sv ====
module ppm_csr_store (
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    ppm_csr_if.store   csr
);

    // ****************************************************************
    // Writable state of the control/status register.
    // ****************************************************************
    ppm_pkg::ppm_level_e level_r;
    ppm_pkg::ppm_level_e level_nxt;
    logic                scratch_r;
    logic                scratch_nxt;

    // Only the low byte lane moves the power level.
    assign level_nxt   = csr.wr_lo ?
                         ppm_pkg::ppm_level_e'(csr.wdata[1:0]) : level_r;
    // The scratch bit lives in the high lane.
    assign scratch_nxt = csr.wr_hi ?
                         csr.wdata[ppm_pkg::PPM_SCRATCH_BIT] : scratch_r;

    // Only rst_n clears this state; a level change never does.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r   <= ppm_pkg::PPM_D0;
            scratch_r <= ppm_pkg::PPM_SCRATCH_RST;
        end else begin
            level_r   <= level_nxt;
            scratch_r <= scratch_nxt;
        end
    end

    assign csr.level   = level_r;
    assign csr.scratch = scratch_r;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_level_takes_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        csr.wr_lo |=> csr.level == $past(csr.wdata[1:0]))
        else $error("Power level did not take the written value.");

    a_scratch_roundtrip: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        csr.wr_hi ##1 (!csr.wr_hi)[*2] |->
        csr.scratch == $past(csr.wdata[ppm_pkg::PPM_SCRATCH_BIT], 2))
        else $error("Scratch bit lost its written value.");

endmodule

// ==== dv/ppm_host.sv ====
module ppm_host (
    input  wire logic        sys_clk,
    input  wire logic [15:0] cfg_rdata,
    input  wire logic        cfg_rvalid,
    output logic      [7:0]  cfg_addr,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic      [1:0]  cfg_be,
    output logic      [15:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // Configuration cycles of the host.
    // ****************************************************************
    initial begin
        cfg_addr = 8'h00;
        cfg_rd = 1'h0;
        cfg_wr = 1'h0;
        cfg_be = 2'h0;
        cfg_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] d);
        @(posedge sys_clk);
        cfg_wr <= 1'h1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'h0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge sys_clk);
        cfg_rd <= 1'h1;
        cfg_addr <= a;
        @(posedge sys_clk);
        cfg_rd <= 1'h0;
        cfg_addr <= ~a;
        #1;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask
endmodule

// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic        sel;
        logic [1:0]  be;
        logic [15:0] wd;
        logic [15:0] csr;
        logic [15:0] cap;
    } ppm_row_s;

    logic        sys_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        sel = 1'h1;
    logic [7:0]  cfg_addr;
    logic        cfg_rd;
    logic        cfg_wr;
    logic [1:0]  cfg_be;
    logic [15:0] cfg_wdata;
    logic [15:0] cfg_rdata;
    logic        cfg_rvalid;
    logic [1:0]  level;
    int          mismatches = 0;
    int          samples_checked = 0;
    ppm_row_s    rows [6] = '{
        '{1'h1, 2'h1, 16'hffff, 16'h000b, 16'h0603},
        '{1'h0, 2'h2, 16'hffff, 16'h0103, 16'h0602},
        '{1'h1, 2'h3, 16'h0001, 16'h0009, 16'h0603},
        '{1'h0, 2'h3, 16'h01ff, 16'h0103, 16'h0602},
        '{1'h1, 2'h1, 16'h0100, 16'h0108, 16'h0603},
        '{1'h0, 2'h0, 16'hffff, 16'h0100, 16'h0602}};

    always #25 sys_clk = ~sys_clk;

    ppm_power_regs dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .revision_select_bit(sel),
        .device_power_level(level));

    ppm_host h (.sys_clk(sys_clk), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    // ****************************************************************
    // Comparison and closing tasks.
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        h.rd(a, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask

    task automatic stop_test;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        rdchk(ppm_pkg::PPM_CSR_OFS, 16'h0008);
        rdchk(ppm_pkg::PPM_CAP_OFS, 16'h0603);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            sel <= rows[i].sel;
            h.wr(ppm_pkg::PPM_CSR_OFS, rows[i].be, rows[i].wd);
            rdchk(ppm_pkg::PPM_CSR_OFS, rows[i].csr);
            rdchk(ppm_pkg::PPM_CAP_OFS, rows[i].cap);
            chk({14'h0000, level}, {14'h0000, rows[i].csr[1:0]});
        end
        h.wr(ppm_pkg::PPM_CAP_OFS, 2'h3, 16'hffff);
        rdchk(ppm_pkg::PPM_CAP_OFS, 16'h0602);
        rdchk(8'h56, 16'h0000);
        @(posedge sys_clk);
        rst_n <= 1'h0;
        @(posedge sys_clk);
        rst_n <= 1'h1;
        rdchk(ppm_pkg::PPM_CSR_OFS, 16'h0000);
        chk({14'h0000, level}, 16'h0000);
        stop_test();
    end
endmodule
